// ---- pkg/serpin_pkg.sv ----
// Purpose: shared constants and types for the serializer pin and reset configuration block
// Assumes: byte-wide registers behind a two-wire configuration link
// Notes: offsets are register indices on the link

package serpin_pkg;

  localparam logic [7:0] REG_ID = 8'h00;
  localparam logic [7:0] REG_CTL = 8'h01;
  localparam logic [7:0] REG_PIN0 = 8'h02;
  localparam logic [7:0] REG_PIN1 = 8'h03;
  localparam logic [7:0] REG_PINIO = 8'h07;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam logic [6:0] ID_RESET = 7'h57;
  localparam int CTL_SRST_BIT = 0;
  localparam int CTL_ADIS_BIT = 4;
  localparam int IO_SWOUT0_BIT = 0;
  localparam int IO_SWOUT1_BIT = 1;
  localparam int IO_IN0_BIT = 4;
  localparam int IO_IN1_BIT = 5;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int LANES = 5;

  localparam logic [3:0] M0_SWOUT = 4'h0;
  localparam logic [3:0] M0_LOSS = 4'h3;
  localparam logic [3:0] M0_PRESENT = 4'h4;
  localparam logic [3:0] M0_POR = 4'h6;
  localparam logic [3:0] M1_POR = 4'h0;
  localparam logic [3:0] M1_SWOUT = 4'h1;
  localparam logic [3:0] M1_PLL = 4'h2;
  localparam logic [3:0] M1_LANE_LO = 4'h4;
  localparam logic [3:0] M1_LANE_HI = 4'h8;

  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] pull;
    logic ibuf;
    logic drive;
  } pin_cfg_s;

  localparam pin_cfg_s PIN_CFG_RESET = '{mode: 4'h0, pull: 2'h1, ibuf: 1'b0, drive: 1'b1};

  typedef struct packed {
    logic o;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic ibuf_en;
  } pad_s;

  typedef struct packed {
    logic [LANES-1:0] lane_loss;
    logic pin1;
    logic pin0;
    logic por;
    logic pll;
    logic present;
    logic loss;
    logic scl;
    logic sda;
  } in_s;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX = 5'h02,
    S_ACK = 5'h04,
    S_TX = 5'h08,
    S_TXACK = 5'h10
  } bus_state_e;

  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_PTR = 3'h2,
    PH_DATA = 3'h4
  } phase_e;

endpackage : serpin_pkg

// ---- hw/serializer_pin_config_reset.sv ----
// Purpose: soft reset, analog disable and two general pins, set over the configuration link
// Assumes: link pins and status inputs are asynchronous and are synchronised here
// Notes: link is open drain, SDA_O stays low and SDA_OE pulls the line

module serializer_pin_config_reset (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic HOST_CLOCK_LOSS,
  input wire logic HOST_CLOCK_PRESENT,
  input wire logic PLL_LOCKED,
  input wire logic POWER_ON_RESET,
  input wire logic [serpin_pkg::LANES-1:0] LANE_SIGNAL_LOSS,
  input wire logic PIN0_I,
  input wire logic PIN1_I,
  output serpin_pkg::pad_s PIN0_PAD,
  output serpin_pkg::pad_s PIN1_PAD,
  output logic ANALOG_DISABLE,
  output logic SOFT_RESET
);

  // input synchronisers
  serpin_pkg::in_s raw;
  serpin_pkg::in_s s1_q;
  serpin_pkg::in_s s2_q;
  logic scl_d_q;
  logic sda_d_q;

  assign raw = '{lane_loss: LANE_SIGNAL_LOSS, pin1: PIN1_I, pin0: PIN0_I, por: POWER_ON_RESET,
                 pll: PLL_LOCKED, present: HOST_CLOCK_PRESENT, loss: HOST_CLOCK_LOSS,
                 scl: SCL, sda: SDA_I};

  always_ff @(posedge CLK) begin
    s1_q <= raw;
    s2_q <= s1_q;
    scl_d_q <= s2_q.scl;
    sda_d_q <= s2_q.sda;
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = s2_q.scl & ~scl_d_q;
  assign scl_fall = ~s2_q.scl & scl_d_q;
  assign start_ev = s2_q.scl & scl_d_q & sda_d_q & ~s2_q.sda;
  assign stop_ev = s2_q.scl & scl_d_q & ~sda_d_q & s2_q.sda;

  // register storage
  logic [6:0] id_q, id_d;
  logic srst_q, srst_d;
  logic adis_q, adis_d;
  serpin_pkg::pin_cfg_s pin0_q, pin0_d, pin1_q, pin1_d;
  logic [1:0] swout_q, swout_d;

  // link engine
  serpin_pkg::bus_state_e st_q, st_d;
  serpin_pkg::phase_e ph_q, ph_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic oe_q, oe_d;
  logic wr_en;
  logic [7:0] rdata;

  always_comb begin
    rdata = serpin_pkg::READ_UNMAPPED;
    if (ptr_q == serpin_pkg::REG_ID) begin
      rdata = {id_q, 1'b0};
    end else if (ptr_q == serpin_pkg::REG_CTL) begin
      rdata[serpin_pkg::CTL_SRST_BIT] = srst_q;
      rdata[serpin_pkg::CTL_ADIS_BIT] = adis_q;
    end else if (ptr_q == serpin_pkg::REG_PIN0) begin
      rdata = pin0_q;
    end else if (ptr_q == serpin_pkg::REG_PIN1) begin
      rdata = pin1_q;
    end else if (ptr_q == serpin_pkg::REG_PINIO) begin
      rdata[serpin_pkg::IO_SWOUT0_BIT] = swout_q[0];
      rdata[serpin_pkg::IO_SWOUT1_BIT] = swout_q[1];
      rdata[serpin_pkg::IO_IN0_BIT] = s2_q.pin0 & pin0_q.ibuf;
      rdata[serpin_pkg::IO_IN1_BIT] = s2_q.pin1 & pin1_q.ibuf;
    end
  end

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    if (start_ev) begin
      st_d = serpin_pkg::S_RX;
      ph_d = serpin_pkg::PH_ADDR;
      bitcnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_ev) begin
      st_d = serpin_pkg::S_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        serpin_pkg::S_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], s2_q.sda};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == serpin_pkg::BYTE_BITS) begin
            st_d = serpin_pkg::S_ACK;
            oe_d = 1'b1;
            case (ph_q)
              serpin_pkg::PH_ADDR: begin
                rw_d = shift_q[0];
                if (shift_q[7:1] != id_q) begin
                  st_d = serpin_pkg::S_IDLE;
                  oe_d = 1'b0;
                end
              end
              serpin_pkg::PH_PTR: ptr_d = shift_q;
              default: begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        serpin_pkg::S_ACK: begin
          if (scl_fall) begin
            bitcnt_d = 4'h0;
            if (rw_q) begin
              st_d = serpin_pkg::S_TX;
              shift_d = rdata;
              oe_d = ~rdata[7];
              bitcnt_d = 4'h1;
            end else begin
              st_d = serpin_pkg::S_RX;
              oe_d = 1'b0;
              ph_d = (ph_q == serpin_pkg::PH_ADDR) ? serpin_pkg::PH_PTR : serpin_pkg::PH_DATA;
            end
          end
        end
        serpin_pkg::S_TX: begin
          if (scl_fall) begin
            if (bitcnt_q == serpin_pkg::BYTE_BITS) begin
              st_d = serpin_pkg::S_TXACK;
              oe_d = 1'b0;
            end else begin
              oe_d = ~shift_q[6];
              shift_d = {shift_q[6:0], 1'b0};
              bitcnt_d = bitcnt_q + 4'h1;
            end
          end
        end
        serpin_pkg::S_TXACK: begin
          if (scl_rise) begin
            if (s2_q.sda) begin
              st_d = serpin_pkg::S_IDLE;
            end else begin
              st_d = serpin_pkg::S_ACK;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        default: st_d = serpin_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_q <= serpin_pkg::S_IDLE;
      ph_q <= serpin_pkg::PH_ADDR;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
    end
  end

  // register writes and soft reset
  always_comb begin
    id_d = id_q;
    srst_d = srst_q;
    adis_d = adis_q;
    pin0_d = pin0_q;
    pin1_d = pin1_q;
    swout_d = swout_q;
    if (srst_q) begin
      srst_d = 1'b0;
      adis_d = 1'b0;
      pin0_d = serpin_pkg::PIN_CFG_RESET;
      pin1_d = serpin_pkg::PIN_CFG_RESET;
      swout_d = 2'h0;
    end else if (wr_en) begin
      if (ptr_q == serpin_pkg::REG_ID) begin
        id_d = shift_q[7:1];
      end else if (ptr_q == serpin_pkg::REG_CTL) begin
        srst_d = shift_q[serpin_pkg::CTL_SRST_BIT];
        adis_d = shift_q[serpin_pkg::CTL_ADIS_BIT];
      end else if (ptr_q == serpin_pkg::REG_PIN0) begin
        pin0_d = shift_q;
      end else if (ptr_q == serpin_pkg::REG_PIN1) begin
        pin1_d = shift_q;
      end else if (ptr_q == serpin_pkg::REG_PINIO) begin
        swout_d = {shift_q[serpin_pkg::IO_SWOUT1_BIT], shift_q[serpin_pkg::IO_SWOUT0_BIT]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      id_q <= serpin_pkg::ID_RESET;
      srst_q <= 1'b0;
      adis_q <= 1'b0;
      pin0_q <= serpin_pkg::PIN_CFG_RESET;
      pin1_q <= serpin_pkg::PIN_CFG_RESET;
      swout_q <= 2'h0;
    end else begin
      id_q <= id_d;
      srst_q <= srst_d;
      adis_q <= adis_d;
      pin0_q <= pin0_d;
      pin1_q <= pin1_d;
      swout_q <= swout_d;
    end
  end

  // pin sources and pads
  logic [3:0] lane_off;
  logic lane_pick;
  serpin_pkg::pad_s pad0_d, pad1_d;
  assign lane_off = pin1_q.mode - serpin_pkg::M1_LANE_LO;
  assign lane_pick = s2_q.lane_loss[lane_off[2:0]];
  logic lane_mode;
  assign lane_mode = pin1_q.mode >= serpin_pkg::M1_LANE_LO
                     && pin1_q.mode <= serpin_pkg::M1_LANE_HI;

  always_comb begin
    pad0_d.o = 1'b0;
    case (pin0_q.mode)
      serpin_pkg::M0_SWOUT: pad0_d.o = swout_q[0];
      serpin_pkg::M0_LOSS: pad0_d.o = s2_q.loss;
      serpin_pkg::M0_PRESENT: pad0_d.o = s2_q.present;
      serpin_pkg::M0_POR: pad0_d.o = s2_q.por;
      default: pad0_d.o = 1'b0;
    endcase
    pad1_d.o = 1'b0;
    if (pin1_q.mode == serpin_pkg::M1_POR) begin
      pad1_d.o = s2_q.por;
    end else if (pin1_q.mode == serpin_pkg::M1_SWOUT) begin
      pad1_d.o = swout_q[1];
    end else if (pin1_q.mode == serpin_pkg::M1_PLL) begin
      pad1_d.o = s2_q.pll;
    end else if (lane_mode) begin
      pad1_d.o = lane_pick;
    end
    pad0_d.oe = pin0_q.drive;
    pad0_d.pull_up = pin0_q.pull == serpin_pkg::PULL_UP;
    pad0_d.pull_down = pin0_q.pull == serpin_pkg::PULL_DOWN;
    pad0_d.ibuf_en = pin0_q.ibuf;
    pad1_d.oe = pin1_q.drive;
    pad1_d.pull_up = pin1_q.pull == serpin_pkg::PULL_UP;
    pad1_d.pull_down = pin1_q.pull == serpin_pkg::PULL_DOWN;
    pad1_d.ibuf_en = pin1_q.ibuf;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PIN0_PAD <= '0;
      PIN1_PAD <= '0;
      ANALOG_DISABLE <= 1'b0;
      SOFT_RESET <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      PIN0_PAD <= pad0_d;
      PIN1_PAD <= pad1_d;
      ANALOG_DISABLE <= adis_q;
      SOFT_RESET <= srst_q;
      SDA_O <= 1'b0;
      SDA_OE <= oe_q;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_soft_reset;
    srst_q |=> !srst_q && pin0_q == serpin_pkg::PIN_CFG_RESET && !adis_q && id_q == $past(id_q);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

  property p_analog;
    adis_q && !srst_q |=> ANALOG_DISABLE;
  endproperty
  a_analog: assert property (p_analog) else $error("analog disable not shown");

  property p_addr_miss;
    st_q == serpin_pkg::S_RX && ph_q == serpin_pkg::PH_ADDR && scl_fall && !start_ev && !stop_ev
      && bitcnt_q == serpin_pkg::BYTE_BITS && shift_q[7:1] != id_q
      |=> st_q == serpin_pkg::S_IDLE && !oe_q;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

  property p_pin0_sw;
    pin0_q.mode == serpin_pkg::M0_SWOUT |=> PIN0_PAD.o == $past(swout_q[0]);
  endproperty
  a_pin0_sw: assert property (p_pin0_sw) else $error("pin0 software source wrong");

  property p_pin0_loss;
    pin0_q.mode == serpin_pkg::M0_LOSS |=> PIN0_PAD.o == $past(s2_q.loss);
  endproperty
  a_pin0_loss: assert property (p_pin0_loss) else $error("pin0 clock loss wrong");

  property p_pin0_por;
    pin0_q.mode == serpin_pkg::M0_POR |=> PIN0_PAD.o == $past(s2_q.por);
  endproperty
  a_pin0_por: assert property (p_pin0_por) else $error("pin0 por wrong");

  property p_pull;
    RST_B |=> PIN0_PAD.pull_down == ($past(pin0_q.pull) == serpin_pkg::PULL_DOWN)
      && !(PIN0_PAD.pull_up && PIN0_PAD.pull_down);
  endproperty
  a_pull: assert property (p_pull) else $error("pull decode wrong");

  property p_ibuf_oe;
    RST_B |=> PIN0_PAD.ibuf_en == $past(pin0_q.ibuf) && PIN0_PAD.oe == $past(pin0_q.drive);
  endproperty
  a_ibuf_oe: assert property (p_ibuf_oe) else $error("buffer or driver enable wrong");

  property p_pin1_pll;
    pin1_q.mode == serpin_pkg::M1_PLL |=> PIN1_PAD.o == $past(s2_q.pll);
  endproperty
  a_pin1_pll: assert property (p_pin1_pll) else $error("pin1 pll wrong");

  property p_pin1_lane;
    pin1_q.mode >= serpin_pkg::M1_LANE_LO && pin1_q.mode <= serpin_pkg::M1_LANE_HI
      |=> PIN1_PAD.o == $past(lane_pick);
  endproperty
  a_pin1_lane: assert property (p_pin1_lane) else $error("pin1 lane loss wrong");

  property p_reserved;
    pin0_q.mode == 4'hF |=> !PIN0_PAD.o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drives pin");

  c_soft_reset: cover property (srst_q ##1 !srst_q);
  c_write: cover property (wr_en);
  c_read: cover property (st_q == serpin_pkg::S_TX ##[1:200] st_q == serpin_pkg::S_TXACK);

endmodule : serializer_pin_config_reset

// ---- bench/smbus_host.sv ----
// Purpose: host model, master of the two-wire configuration link
// Assumes: sda is the wired line with a pull-up, scl is driven push-pull
// Notes: each bit holds scl high for H clock cycles and low for H+2, ninth bit of every byte released by the host
module smbus_host #(
  parameter int H = 6
) (
  input wire logic clk,
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // start or repeated start, leaves scl low
  task automatic go();
    sda_pull <= 1'b0;
    wt(H);
    scl <= 1'b1;
    wt(H);
    sda_pull <= 1'b1;
    wt(H);
    scl <= 1'b0;
    wt(H);
  endtask : go

  task automatic halt();
    sda_pull <= 1'b1;
    wt(H);
    scl <= 1'b1;
    wt(H);
    sda_pull <= 1'b0;
    wt(2 * H);
  endtask : halt

  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= ~b;
    wt(H);
    scl <= 1'b1;
    wt(H);
    s = sda;
    scl <= 1'b0;
    wt(2);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : byte_io

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    go();
    byte_io({a, 1'b0}, q, k0);
    byte_io(p, q, k1);
    byte_io(d, q, k2);
    halt();
    ok = k0 & k1 & k2;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                          output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    go();
    byte_io({a, 1'b0}, q, k0);
    byte_io(p, q, k1);
    go();
    byte_io({a, 1'b1}, q, k2);
    byte_io(8'hFF, d, k3);
    halt();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : smbus_host

// ---- bench/serializer_pin_config_reset_tb_top.sv ----
// Purpose: self-checking bench for the pin and reset configuration block
// Assumes: host model on the link, pull-up on the data line
// Notes: status and pad inputs change on the rising edge
module serializer_pin_config_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, scl, pull, sda, sda_o, sda_oe, loss, pres, pll, por, p0i, p1i, adis, srst;
  logic [4:0] lane;
  serpin_pkg::pad_s pad0, pad1;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int sr_n = 0;
  logic [6:0] id = serpin_pkg::ID_RESET;

  assign sda = ~(pull | (sda_oe & ~sda_o));
  smbus_host host (.clk(clk), .scl(scl), .sda_pull(pull), .sda(sda));
  serializer_pin_config_reset dut (.CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .HOST_CLOCK_LOSS(loss), .HOST_CLOCK_PRESENT(pres),
    .PLL_LOCKED(pll), .POWER_ON_RESET(por), .LANE_SIGNAL_LOSS(lane), .PIN0_I(p0i),
    .PIN1_I(p1i), .PIN0_PAD(pad0), .PIN1_PAD(pad1), .ANALOG_DISABLE(adis), .SOFT_RESET(srst));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc <= cyc + 1;
    sr_n <= sr_n + int'(srst === 1'b1);
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] pexp(input logic o, input logic [7:0] c);
    return {3'h0, o, c[0], c[3:2] == 2'h2, c[3:2] == 2'h1, c[1]};
  endfunction : pexp

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    host.write_reg(id, p, d, ok);
    check("write ack", {7'h0, ok}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    host.read_reg(id, p, d, ok);
    check("read ack", {7'h0, ok}, 8'h01);
    check("read data", d, e);
  endtask : rd

  task automatic t_reset();
    rd(serpin_pkg::REG_ID, {serpin_pkg::ID_RESET, 1'b0});
    rd(serpin_pkg::REG_CTL, 8'h00);
    rd(serpin_pkg::REG_PIN0, 8'h05);
    rd(serpin_pkg::REG_PIN1, 8'h05);
    check("pin0 pad", {3'h0, pad0}, pexp(1'b0, 8'h05));
    check("pin1 pad", {3'h0, pad1}, pexp(por, 8'h05));
  endtask : t_reset

  // four status patterns give every source a distinct signature
  task automatic t_sources();
    logic [4:0] lp [4] = '{5'h01, 5'h12, 5'h14, 5'h18};
    logic [3:0] c0 [6] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h1, 4'hF};
    logic e, sw;
    logic [7:0] cfg;
    for (int k = 0; k < 4; k++) begin
      sw = ~k[0];
      loss <= k[0];
      pres <= k[1];
      por <= k[0] ^ k[1];
      pll <= ~k[1];
      lane <= lp[k];
      wr(serpin_pkg::REG_PINIO, {6'h0, sw, sw});
      foreach (c0[i]) begin
        e = c0[i] == 4'h0 ? sw : c0[i] == 4'h3 ? loss : c0[i] == 4'h4 ? pres :
            c0[i] == 4'h6 ? por : 1'b0;
        cfg = {c0[i], 4'h5};
        wr(serpin_pkg::REG_PIN0, cfg);
        check("pin0 source", {3'h0, pad0}, pexp(e, cfg));
      end
      for (int c = 0; c < 11; c++) begin
        e = c == 0 ? por : c == 1 ? sw : c == 2 ? pll : (c > 3 && c < 9) ? lane[c - 4] : 1'b0;
        cfg = {4'(c), 4'h5};
        wr(serpin_pkg::REG_PIN1, cfg);
        check("pin1 source", {3'h0, pad1}, pexp(e, cfg));
      end
    end
  endtask : t_sources

  task automatic t_pads();
    wr(serpin_pkg::REG_PINIO, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(serpin_pkg::REG_PIN0, {4'h0, 4'(i)});
      check("pin0 pad bits", {3'h0, pad0}, pexp(1'b0, 8'(i)));
    end
    wr(serpin_pkg::REG_PIN0, 8'h04);
    wr(serpin_pkg::REG_PIN1, 8'h04);
    p0i <= 1'b1;
    p1i <= 1'b1;
    wr(serpin_pkg::REG_PINIO, 8'hFF);
    wr(serpin_pkg::REG_PIN0, 8'h06);
    rd(serpin_pkg::REG_PINIO, 8'h13);
    wr(serpin_pkg::REG_PIN1, 8'h06);
    rd(serpin_pkg::REG_PINIO, 8'h33);
    p0i <= 1'b0;
    p1i <= 1'b0;
    rd(serpin_pkg::REG_PINIO, 8'h03);
    wr(serpin_pkg::REG_PIN0, 8'h05);
    wr(serpin_pkg::REG_PIN1, 8'h05);
  endtask : t_pads

  task automatic t_ctl();
    wr(serpin_pkg::REG_CTL, 8'hFE);
    rd(serpin_pkg::REG_CTL, 8'h10);
    check("analog disable", {7'h0, adis}, 8'h01);
  endtask : t_ctl

  task automatic t_srst();
    int n0;
    logic ok;
    logic [7:0] d;
    wr(serpin_pkg::REG_PIN0, 8'h61);
    wr(serpin_pkg::REG_ID, 8'h42);
    id = 7'h21;
    rd(serpin_pkg::REG_ID, 8'h42);
    n0 = sr_n;
    wr(serpin_pkg::REG_CTL, 8'h11);
    check("soft reset pulses", 8'(sr_n - n0), 8'h01);
    check("analog after reset", {7'h0, adis}, 8'h00);
    rd(serpin_pkg::REG_CTL, 8'h00);
    rd(serpin_pkg::REG_PIN0, 8'h05);
    rd(serpin_pkg::REG_ID, 8'h42);
    host.read_reg(serpin_pkg::ID_RESET, serpin_pkg::REG_ID, d, ok);
    check("old address refused", {7'h0, ok}, 8'h00);
  endtask : t_srst

  initial begin
    rst_b = 1'b0;
    loss = 1'b0;
    pres = 1'b0;
    pll = 1'b0;
    por = 1'b0;
    lane = 5'h00;
    p0i = 1'b0;
    p1i = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_sources();
    t_pads();
    t_ctl();
    t_srst();
    close_out();
  end
endmodule : serializer_pin_config_reset_tb_top
